// ==== include/gain_limiter_brownout_config_map.vh ====
// Register offsets, reset values, writable masks and field codes of the gain and brownout bank
`ifndef GAIN_LIMITER_BROWNOUT_CONFIG_MAP_VH
`define GAIN_LIMITER_BROWNOUT_CONFIG_MAP_VH
// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define OFS_SHARED_PIN 8'h15
`define OFS_AUDIO_SLOT 8'h16
`define OFS_ALIGN_START 8'h17
`define OFS_ALIGN_GROUP 8'h18
`define OFS_TONE 8'h19
`define OFS_VOLUME 8'h1A
`define OFS_PEAK_ATTACK 8'h1B
`define OFS_PEAK_RELEASE 8'h1C
`define OFS_SAG_MAIN 8'h1D
`define OFS_SAG_HOLD 8'h1E
`define OFS_SAG3_DWELL 8'h1F
`define OFS_SAG3_RATE 8'h20
// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_SHARED_PIN 8'h00
`define RST_AUDIO_SLOT 8'h12
`define RST_ALIGN_START 8'h0C
`define RST_ALIGN_GROUP 8'h00
`define RST_TONE 8'h0D
`define RST_VOLUME 8'h00
`define RST_PEAK_ATTACK 8'h22
`define RST_PEAK_RELEASE 8'h32
`define RST_SAG_MAIN 8'h40
`define RST_SAG_HOLD 8'h32
`define RST_SAG3_DWELL 8'h02
`define RST_SAG3_RATE 8'h06
// ---------------------------------------------------------------
// Writable bit masks (reserved bits read zero)
// ---------------------------------------------------------------
`define MSK_SHARED_PIN 8'h1C
`define MSK_PEAK_ATTACK 8'h3F
`define MSK_SAG_MAIN 8'hFB
`define MSK_SAG_STEP 8'hFE
// ---------------------------------------------------------------
// Field codes and limits
// ---------------------------------------------------------------
`define PIN_ALIGN 3'h0
`define PIN_BUF_OFF 3'h2
`define PIN_GP_IN 3'h3
`define PIN_GP_OUT 3'h4
`define VOL_MAX 8'hC8
`define TONE_MAX 5'h0E
`define ATK_MAX 4'h9
`define ATK_LAST 4'hC
`define RLS_LAST 4'hC
`define HEADROOM_MAX 5'h10
`define ATTEN_MAX 7'h2F
`define SLOT_STRIDE 7'h03
`endif

// ==== logic/gain_limiter_brownout_config.v ====
// Gain, peak limiter and brownout configuration bank with its decoded controls
// Behaviour
// - Shared pin function codes 0,2,3,4 decoded
// - Audio sent in chosen slot, 16/24 bits
// - Sag gain alignment follows its enable bit
// - Peak alignment follows its enable bit
// - Group slot n is start plus 3n
// - Combine by sum or by larger attenuation
// - Tone source select with clock choice
// - Volume 0.5 dB steps, above C8h mutes
// - Limiter gated by enable; headroom tracking bit
// - Attack rate 20 us/dB doubling per code
// - Pause bit stops limiter during brownout
// - Release rate 4 ms/dB doubling per code
// - Hold time table 0 to 1000 ms
// - Headroom -20% to 20% in 2.5% steps
// - Level 0 attenuates or mutes then shuts
// - Brownout acts only while enabled
// - Hold clear write one, self clears
// - Total attenuation capped at device maximum
// - Level 3 dwell time table
// - Level 3 attack step table
// - Level 3 attack interval table
// - Level 3 release step mirrors attack
`timescale 1ns/1ps
`include "gain_limiter_brownout_config_map.vh"
module gain_limiter_brownout_config (
    input wire SYS_CLK,
    input wire RST_N,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire SHARED_PIN_IN,
    output reg SHARED_PIN_OUT,
    output reg SHARED_PIN_OE,
    input wire GP_OUT_LEVEL,
    output reg GP_IN_LEVEL,
    output reg GAIN_ALIGN_PIN,
    output reg AUDIO_TX_ON,
    output reg [5:0] AUDIO_SLOT,
    output reg [4:0] AUDIO_SLOT_BITS,
    output reg SAG_ALIGN_ON,
    output reg PEAK_ALIGN_ON,
    output reg [63:0] ALIGN_SLOT_MASK,
    output reg [4:0] TONE_SOURCE,
    output reg TONE_EXT_CLOCK,
    output reg [7:0] VOLUME_HALF_DB,
    output reg VOLUME_MUTE,
    input wire [6:0] PEAK_ATTEN_DB,
    input wire [6:0] SAG_ATTEN_DB,
    input wire SAG_ACTIVE,
    input wire SAG_LEVEL0,
    output reg [6:0] TOTAL_ATTEN_DB,
    output reg PEAK_RUN,
    output reg HEADROOM_TRACK,
    output reg [16:0] PEAK_ATTACK_US_PER_DB,
    output reg [13:0] PEAK_RELEASE_MS_PER_DB,
    output reg [9:0] PEAK_HOLD_MS,
    output reg signed [8:0] HEADROOM_PERMILLE,
    output reg SAG_RUN,
    output reg SAG_MUTE_SHUTDOWN,
    output reg SAG_LEVEL0_ATTEN,
    output reg SAG_HOLD_RELEASE,
    output reg [13:0] SAG3_DWELL_US,
    output reg [15:0] SAG3_ATTACK_STEP,
    output reg [12:0] SAG3_ATTACK_TENTH_US,
    output reg [15:0] SAG3_RELEASE_STEP
);
// ---------------------------------------------------------------
// Lookup functions
// ---------------------------------------------------------------
// Step size in units of 0.0001 dB, shared by attack and release
function [15:0] step_size;
    input [3:0] code;
    begin
        case (code)
            4'h0: step_size = 16'h0271;
            4'h1: step_size = 16'h1388;
            4'h2: step_size = 16'h22FE;
            4'h3: step_size = 16'h3274;
            4'h4: step_size = 16'h41EA;
            4'h5: step_size = 16'h5160;
            4'h6: step_size = 16'h60D6;
            4'h7: step_size = 16'h704C;
            4'h8: step_size = 16'h7FC2;
            4'h9: step_size = 16'h8F38;
            4'hA: step_size = 16'h9EAE;
            4'hB: step_size = 16'hAE24;
            4'hC: step_size = 16'hBD9A;
            4'hD: step_size = 16'hCD10;
            4'hE: step_size = 16'hDC86;
            default: step_size = 16'hEA60;
        endcase
    end
endfunction

// Slot of group member n; beyond 63 it falls off the bus
function [6:0] group_slot;
    input [5:0] start;
    input [2:0] n;
    begin
        group_slot = {1'b0, start} + (`SLOT_STRIDE * {4'h0, n});
    end
endfunction

// ---------------------------------------------------------------
// Registers
// ---------------------------------------------------------------
reg [7:0] shared_pin;
reg [7:0] audio_slot;
reg [7:0] align_start;
reg [7:0] align_group;
reg [7:0] tone;
reg [7:0] volume;
reg [7:0] peak_attack;
reg [7:0] peak_release;
reg [7:0] sag_main;
reg [7:0] sag_hold;
reg [7:0] sag3_dwell;
reg [7:0] sag3_rate;
reg [7:0] next_rdata;

always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
        shared_pin <= `RST_SHARED_PIN;
        audio_slot <= `RST_AUDIO_SLOT;
        align_start <= `RST_ALIGN_START;
        align_group <= `RST_ALIGN_GROUP;
        tone <= `RST_TONE;
        volume <= `RST_VOLUME;
        peak_attack <= `RST_PEAK_ATTACK;
        peak_release <= `RST_PEAK_RELEASE;
        sag_main <= `RST_SAG_MAIN;
        sag_hold <= `RST_SAG_HOLD;
        sag3_dwell <= `RST_SAG3_DWELL;
        sag3_rate <= `RST_SAG3_RATE;
    end else begin
        // Hold clear lives one cycle; a new write of one re-arms it
        sag_hold[7] <= 1'b0;
        if (REG_WR) begin
            case (REG_ADDR)
                `OFS_SHARED_PIN: shared_pin <= REG_WDATA & `MSK_SHARED_PIN;
                `OFS_AUDIO_SLOT: audio_slot <= REG_WDATA;
                `OFS_ALIGN_START: align_start <= REG_WDATA;
                `OFS_ALIGN_GROUP: align_group <= REG_WDATA;
                `OFS_TONE: tone <= REG_WDATA;
                `OFS_VOLUME: volume <= REG_WDATA;
                `OFS_PEAK_ATTACK: peak_attack <= REG_WDATA & `MSK_PEAK_ATTACK;
                `OFS_PEAK_RELEASE: peak_release <= REG_WDATA;
                `OFS_SAG_MAIN: sag_main <= REG_WDATA & `MSK_SAG_MAIN;
                `OFS_SAG_HOLD: begin
                    sag_hold[6:0] <= REG_WDATA[6:0];
                    sag_hold[7] <= REG_WDATA[7];
                end
                `OFS_SAG3_DWELL: sag3_dwell <= REG_WDATA & `MSK_SAG_STEP;
                `OFS_SAG3_RATE: sag3_rate <= REG_WDATA & `MSK_SAG_STEP;
                default: ;
            endcase
        end
    end
end

// ---------------------------------------------------------------
// Read path
// ---------------------------------------------------------------
// Unmapped offsets read zero so software probing never sees stale data
always @* begin
    case (REG_ADDR)
        `OFS_SHARED_PIN: next_rdata = shared_pin;
        `OFS_AUDIO_SLOT: next_rdata = audio_slot;
        `OFS_ALIGN_START: next_rdata = align_start;
        `OFS_ALIGN_GROUP: next_rdata = align_group;
        `OFS_TONE: next_rdata = tone;
        `OFS_VOLUME: next_rdata = volume;
        `OFS_PEAK_ATTACK: next_rdata = peak_attack;
        `OFS_PEAK_RELEASE: next_rdata = peak_release;
        `OFS_SAG_MAIN: next_rdata = sag_main;
        `OFS_SAG_HOLD: next_rdata = sag_hold;
        `OFS_SAG3_DWELL: next_rdata = sag3_dwell;
        `OFS_SAG3_RATE: next_rdata = sag3_rate;
        default: next_rdata = 8'h00;
    endcase
end

always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
        REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
        REG_RDATA <= next_rdata;
    end
end

// ---------------------------------------------------------------
// Shared pin synchroniser
// ---------------------------------------------------------------
// Third stage lets a change count only once two stages agree
reg [2:0] pin_sync;
always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
        pin_sync <= 3'b000;
        GP_IN_LEVEL <= 1'b0;
    end else begin
        pin_sync <= {pin_sync[1:0], SHARED_PIN_IN};
        if (pin_sync[1] == pin_sync[2]) begin
            GP_IN_LEVEL <= pin_sync[2];
        end
    end
end

// ---------------------------------------------------------------
// Decoded controls
// ---------------------------------------------------------------
wire [2:0] pin_mode = shared_pin[4:2];
wire [5:0] start_slot = align_start[6:1];
wire [3:0] atk_code = peak_attack[4:1];
wire [3:0] rls_code = peak_release[6:3];
wire [4:0] headroom_code = sag_main[7:3];
wire peak_on = peak_attack[0] && !(peak_release[7] && SAG_ACTIVE);
wire sag_on = sag_main[0];
wire [6:0] peak_part = peak_on ? PEAK_ATTEN_DB : 7'h00;
wire [6:0] sag_part = sag_on ? SAG_ATTEN_DB : 7'h00;
wire [7:0] att_sum = {1'b0, peak_part} + {1'b0, sag_part};
wire [6:0] att_cap = (sag_hold[6:0] > `ATTEN_MAX) ? `ATTEN_MAX : sag_hold[6:0];
reg [7:0] att_pick;
reg [63:0] next_mask;
reg [6:0] slot_n;
integer n;

always @* begin
    // Group membership decoded per enable bit
    next_mask = 64'h0000_0000_0000_0000;
    slot_n = 7'h00;
    for (n = 0; n < 8; n = n + 1) begin
        slot_n = group_slot(start_slot, n[2:0]);
        if (align_group[n] && !slot_n[6]) begin
            next_mask[slot_n[5:0]] = 1'b1;
        end
    end
end

// ---------------------------------------------------------------
// Attenuation combine
// ---------------------------------------------------------------
// Combine mode here; the device ceiling follows in the output stage
always @* begin
    if (tone[5]) begin
        att_pick = (peak_part > sag_part) ? {1'b0, peak_part} : {1'b0, sag_part};
    end else begin
        att_pick = att_sum;
    end
end

// ---------------------------------------------------------------
// Output registers
// ---------------------------------------------------------------
always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
        SHARED_PIN_OUT <= 1'b0;
        SHARED_PIN_OE <= 1'b0;
        GAIN_ALIGN_PIN <= 1'b0;
        AUDIO_TX_ON <= 1'b0;
        AUDIO_SLOT <= 6'h00;
        AUDIO_SLOT_BITS <= 5'h00;
        SAG_ALIGN_ON <= 1'b0;
        PEAK_ALIGN_ON <= 1'b0;
        ALIGN_SLOT_MASK <= 64'h0000_0000_0000_0000;
        TONE_SOURCE <= 5'h00;
        TONE_EXT_CLOCK <= 1'b0;
        VOLUME_HALF_DB <= 8'h00;
        VOLUME_MUTE <= 1'b0;
        TOTAL_ATTEN_DB <= 7'h00;
        PEAK_RUN <= 1'b0;
        HEADROOM_TRACK <= 1'b0;
        PEAK_ATTACK_US_PER_DB <= 17'h0_0000;
        PEAK_RELEASE_MS_PER_DB <= 14'h0000;
        PEAK_HOLD_MS <= 10'h000;
        HEADROOM_PERMILLE <= 9'h000;
        SAG_RUN <= 1'b0;
        SAG_MUTE_SHUTDOWN <= 1'b0;
        SAG_LEVEL0_ATTEN <= 1'b0;
        SAG_HOLD_RELEASE <= 1'b0;
        SAG3_DWELL_US <= 14'h0000;
        SAG3_ATTACK_STEP <= 16'h0000;
        SAG3_ATTACK_TENTH_US <= 13'h0000;
        SAG3_RELEASE_STEP <= 16'h0000;
    end else begin
        // Reserved pin codes leave the buffers off, the safe state
        GAIN_ALIGN_PIN <= (pin_mode == `PIN_ALIGN);
        SHARED_PIN_OE <= (pin_mode == `PIN_GP_OUT);
        SHARED_PIN_OUT <= (pin_mode == `PIN_GP_OUT) && GP_OUT_LEVEL;

        AUDIO_TX_ON <= audio_slot[6];
        AUDIO_SLOT <= audio_slot[5:0];
        AUDIO_SLOT_BITS <= audio_slot[7] ? 5'h18 : 5'h10;

        SAG_ALIGN_ON <= align_start[7] && (pin_mode == `PIN_ALIGN);
        PEAK_ALIGN_ON <= align_start[0] && (pin_mode == `PIN_ALIGN);
        ALIGN_SLOT_MASK <= align_start[0] ? next_mask : 64'h0000_0000_0000_0000;

        TONE_SOURCE <= (tone[4:0] > `TONE_MAX) ? 5'h00 : tone[4:0];
        TONE_EXT_CLOCK <= tone[6];

        VOLUME_HALF_DB <= (volume > `VOL_MAX) ? `VOL_MAX : volume;
        VOLUME_MUTE <= (volume > `VOL_MAX);

        // Ceiling applied last so neither combine mode can pass it
        TOTAL_ATTEN_DB <= (att_pick > {1'b0, att_cap}) ? att_cap : att_pick[6:0];
        PEAK_RUN <= peak_on;
        HEADROOM_TRACK <= peak_attack[5];

        // Codes past the table report zero, marking them unusable
        if (atk_code <= `ATK_LAST) begin
            PEAK_ATTACK_US_PER_DB <= 17'h0_0014 << atk_code;
        end else begin
            PEAK_ATTACK_US_PER_DB <= 17'h0_0000;
        end
        if (rls_code != 4'h0 && rls_code <= `RLS_LAST) begin
            PEAK_RELEASE_MS_PER_DB <= 14'h0002 << rls_code;
        end else begin
            PEAK_RELEASE_MS_PER_DB <= 14'h0000;
        end
        case (peak_release[2:0])
            3'h0: PEAK_HOLD_MS <= 10'h000;
            3'h1: PEAK_HOLD_MS <= 10'h00A;
            3'h2: PEAK_HOLD_MS <= 10'h019;
            3'h3: PEAK_HOLD_MS <= 10'h032;
            3'h4: PEAK_HOLD_MS <= 10'h064;
            3'h5: PEAK_HOLD_MS <= 10'h0FA;
            3'h6: PEAK_HOLD_MS <= 10'h1F4;
            default: PEAK_HOLD_MS <= 10'h3E8;
        endcase

        if (headroom_code <= `HEADROOM_MAX) begin
            HEADROOM_PERMILLE <= $signed({4'h0, headroom_code}) * 9'sd25 - 9'sd200;
        end else begin
            HEADROOM_PERMILLE <= 9'sd200;
        end

        // A disabled guard never mutes or shuts down, whatever level 0 says
        SAG_RUN <= sag_on;
        SAG_MUTE_SHUTDOWN <= sag_on && SAG_LEVEL0 && sag_main[1];
        SAG_LEVEL0_ATTEN <= sag_on && SAG_LEVEL0 && !sag_main[1];
        SAG_HOLD_RELEASE <= sag_hold[7];

        // Level 3 tables feed the brownout engine, which sits outside
        case (sag3_dwell[7:5])
            3'h0: SAG3_DWELL_US <= 14'h0000;
            3'h1: SAG3_DWELL_US <= 14'h0064;
            3'h2: SAG3_DWELL_US <= 14'h00FA;
            3'h3: SAG3_DWELL_US <= 14'h01F4;
            3'h4: SAG3_DWELL_US <= 14'h03E8;
            3'h5: SAG3_DWELL_US <= 14'h07D0;
            3'h6: SAG3_DWELL_US <= 14'h0FA0;
            default: SAG3_DWELL_US <= 14'h1F40;
        endcase
        SAG3_ATTACK_STEP <= step_size(sag3_dwell[4:1]);
        case (sag3_rate[7:5])
            3'h0: SAG3_ATTACK_TENTH_US <= 13'h0019;
            3'h1: SAG3_ATTACK_TENTH_US <= 13'h0032;
            3'h2: SAG3_ATTACK_TENTH_US <= 13'h0064;
            3'h3: SAG3_ATTACK_TENTH_US <= 13'h00FA;
            3'h4: SAG3_ATTACK_TENTH_US <= 13'h01F4;
            3'h5: SAG3_ATTACK_TENTH_US <= 13'h03E8;
            3'h6: SAG3_ATTACK_TENTH_US <= 13'h09C4;
            default: SAG3_ATTACK_TENTH_US <= 13'h1388;
        endcase
        SAG3_RELEASE_STEP <= step_size(sag3_rate[4:1]);
    end
end

endmodule // gain_limiter_brownout_config

// ==== tb/far_side_model.sv ====
// Model of the gain engines and the peer device on the shared pin
`timescale 1ns/1ps
module far_side_model (
    input wire logic SYS_CLK,
    input wire logic [6:0] peak_cmd,
    input wire logic [6:0] sag_cmd,
    input wire logic active_cmd,
    input wire logic level0_cmd,
    input wire logic peer_drive,
    input wire logic peer_level,
    input wire logic SHARED_PIN_OUT,
    input wire logic SHARED_PIN_OE,
    output logic [6:0] PEAK_ATTEN_DB,
    output logic [6:0] SAG_ATTEN_DB,
    output logic SAG_ACTIVE,
    output logic SAG_LEVEL0,
    output wire logic SHARED_PIN_IN
);
    initial begin
        PEAK_ATTEN_DB = 7'h00;
        SAG_ATTEN_DB = 7'h00;
        SAG_ACTIVE = 1'b0;
        SAG_LEVEL0 = 1'b0;
    end
    // Engine results land one cycle after a command, like a real tracker
    always @(posedge SYS_CLK) begin
        PEAK_ATTEN_DB <= peak_cmd;
        SAG_ATTEN_DB <= sag_cmd;
        SAG_ACTIVE <= active_cmd;
        SAG_LEVEL0 <= level0_cmd;
    end
    // Pull-up wins when nobody drives, so a released pin never reads stale
    assign SHARED_PIN_IN = SHARED_PIN_OE ? SHARED_PIN_OUT : (peer_drive ? peer_level : 1'b1);
endmodule // far_side_model

// ==== tb/gain_limiter_brownout_config_tb.sv ====
// Self-checking testbench of the gain and brownout bank
`timescale 1ns/1ps
module gain_limiter_brownout_config_tb;
    logic SYS_CLK, RST_N, REG_WR, REG_RD, SHARED_PIN_IN, SHARED_PIN_OUT, SHARED_PIN_OE;
    logic GP_OUT_LEVEL, GP_IN_LEVEL, GAIN_ALIGN_PIN, AUDIO_TX_ON, SAG_ALIGN_ON, PEAK_ALIGN_ON;
    logic TONE_EXT_CLOCK, VOLUME_MUTE, SAG_ACTIVE, SAG_LEVEL0, PEAK_RUN, HEADROOM_TRACK, SAG_RUN;
    logic SAG_MUTE_SHUTDOWN, SAG_LEVEL0_ATTEN, SAG_HOLD_RELEASE;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, VOLUME_HALF_DB;
    logic [6:0] PEAK_ATTEN_DB, SAG_ATTEN_DB, TOTAL_ATTEN_DB, peak_cmd, sag_cmd;
    logic [5:0] AUDIO_SLOT;
    logic [4:0] AUDIO_SLOT_BITS, TONE_SOURCE, cc;
    logic [63:0] ALIGN_SLOT_MASK, mask;
    logic [16:0] PEAK_ATTACK_US_PER_DB;
    logic [13:0] PEAK_RELEASE_MS_PER_DB, SAG3_DWELL_US;
    logic [9:0] PEAK_HOLD_MS;
    logic signed [8:0] HEADROOM_PERMILLE, h;
    logic [15:0] SAG3_ATTACK_STEP, SAG3_RELEASE_STEP;
    logic [12:0] SAG3_ATTACK_TENTH_US;
    logic [3:0] k;
    logic [2:0] d;
    logic active_cmd, level0_cmd, peer_drive, peer_level;
    int fails, compares, pulses, p0;
    logic [15:0] steps [16] = '{16'h0271, 16'h1388, 16'h22FE, 16'h3274, 16'h41EA, 16'h5160,
        16'h60D6, 16'h704C, 16'h7FC2, 16'h8F38, 16'h9EAE, 16'hAE24, 16'hBD9A, 16'hCD10,
        16'hDC86, 16'hEA60};
    logic [13:0] dwell [8] = '{14'h0, 14'h64, 14'hFA, 14'h1F4, 14'h3E8, 14'h7D0, 14'hFA0, 14'h1F40};
    logic [12:0] tenth [8] = '{13'h19, 13'h32, 13'h64, 13'hFA, 13'h1F4, 13'h3E8, 13'h9C4, 13'h1388};
    logic [9:0] hold [8] = '{10'h0, 10'hA, 10'h19, 10'h32, 10'h64, 10'hFA, 10'h1F4, 10'h3E8};
    logic [7:0] rstv [12] = '{8'h00, 8'h12, 8'h0C, 8'h00, 8'h0D, 8'h00, 8'h22, 8'h32, 8'h40,
        8'h32, 8'h02, 8'h06};
    logic [7:0] wmsk [12] = '{8'h1C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFB,
        8'h7F, 8'hFE, 8'hFE};
    logic [7:0] vols [5] = '{8'h00, 8'h01, 8'hC8, 8'hC9, 8'hFF};

    gain_limiter_brownout_config gain_limiter_brownout_config_inst (.*);
    far_side_model far_side_model_inst (.*);

    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge SYS_CLK);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = v;
        @(negedge SYS_CLK);
        REG_WR = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge SYS_CLK);
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(negedge SYS_CLK);
        REG_RD = 1'b0;
        chk(REG_RDATA, exp);
    endtask
    // Decoded outputs trail a write by two edges; one spare edge for the engine inputs
    task automatic settle;
        repeat (3) @(negedge SYS_CLK);
    endtask
    task automatic att(input logic [7:0] cmb, lim, pau, sg, cap, input logic [6:0] p, s,
                       input logic a, l0, input logic [6:0] et, input logic [2:0] ex);
        wr(8'h19, cmb);
        wr(8'h1B, lim);
        wr(8'h1C, pau);
        wr(8'h1D, sg);
        wr(8'h1E, cap);
        peak_cmd = p;
        sag_cmd = s;
        active_cmd = a;
        level0_cmd = l0;
        settle;
        chk(TOTAL_ATTEN_DB, et);
        chk({PEAK_RUN, SAG_MUTE_SHUTDOWN, SAG_LEVEL0_ATTEN}, ex);
        chk(SAG_RUN, sg[0]);
    endtask
    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(negedge SYS_CLK) if (SAG_HOLD_RELEASE === 1'b1) pulses++;
    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end
    // Whole run needs about 1100 cycles; the 30000-cycle limit, some 27 times that, means a hang
    initial begin
        #300us;
        fails++;
        summarize;
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {RST_N, REG_WR, REG_RD, GP_OUT_LEVEL, active_cmd, level0_cmd, peer_drive} = 7'h00;
        {REG_ADDR, REG_WDATA, peak_cmd, sag_cmd, peer_level} = 31'h0000_0000;
        repeat (20) @(negedge SYS_CLK);
        RST_N = 1'b1;
        for (int i = 0; i < 12; i++) rd(8'h15 + 8'(i), rstv[i]);
        chk({AUDIO_TX_ON, AUDIO_SLOT, AUDIO_SLOT_BITS}, {1'b0, 6'h12, 5'h10});
        chk({GAIN_ALIGN_PIN, HEADROOM_TRACK, TONE_SOURCE}, 7'h6D);
        wr(8'h21, 8'hFF);
        rd(8'h21, 8'h00);
        rd(8'h14, 8'h00);
        for (int i = 0; i < 12; i++) begin
            wr(8'h15 + 8'(i), 8'hFF);
            rd(8'h15 + 8'(i), wmsk[i]);
        end
        GP_OUT_LEVEL = 1'b1;
        for (int c = 0; c < 8; c++) begin
            wr(8'h15, 8'(c << 2));
            settle;
            chk({GAIN_ALIGN_PIN, SHARED_PIN_OE, SHARED_PIN_OUT}, {c == 0, c == 4, c == 4});
        end
        wr(8'h15, 8'h0C);
        peer_drive = 1'b1;
        repeat (6) @(negedge SYS_CLK);
        chk(GP_IN_LEVEL, 1'b0);
        peer_level = 1'b1;
        repeat (6) @(negedge SYS_CLK);
        chk(GP_IN_LEVEL, 1'b1);
        wr(8'h15, 8'h00);
        for (int i = 0; i < 2; i++) begin
            cc = i ? 5'h02 : 5'h1E;
            wr(8'h16, i ? 8'h05 : 8'hC5);
            wr(8'h17, {1'b1, cc[4:0] * 6'h02, 1'b1});
            wr(8'h18, i ? 8'hA5 : 8'hFF);
            settle;
            mask = 64'h0;
            for (int n = 0; n < 8; n++) begin
                if ((i ? 8'hA5 : 8'hFF) & (8'h01 << n) && 2 * cc + 3 * n < 64) mask[2 * cc + 3 * n] = 1'b1;
            end
            chk(ALIGN_SLOT_MASK, mask);
            chk({SAG_ALIGN_ON, PEAK_ALIGN_ON}, 2'h3);
            chk({AUDIO_TX_ON, AUDIO_SLOT, AUDIO_SLOT_BITS}, i ? 12'h0B0 : 12'h8B8);
        end
        wr(8'h17, 8'h0C);
        settle;
        chk({SAG_ALIGN_ON, PEAK_ALIGN_ON, ALIGN_SLOT_MASK[63:2]}, 64'h0);
        foreach (vols[i]) begin
            wr(8'h1A, vols[i]);
            settle;
            chk({VOLUME_MUTE, VOLUME_HALF_DB}, {vols[i] > 8'hC8, vols[i] > 8'hC8 ? 8'hC8 : vols[i]});
        end
        for (int c = 0; c < 64; c++) begin
            cc = 5'(c);
            wr(8'h19, {1'b0, c[5], 1'b0, cc});
            settle;
            chk({TONE_EXT_CLOCK, TONE_SOURCE}, {c[5], cc <= 5'h0E ? cc : 5'h00});
        end
        for (int c = 0; c < 32; c++) begin
            cc = 5'(c);
            k = cc[3:0];
            d = cc[2:0];
            h = (c <= 16) ? 9'(25 * c - 200) : 9'sh0C8;
            wr(8'h1B, {2'h0, cc[0], k, 1'b0});
            wr(8'h1C, {1'b0, k, d});
            wr(8'h1D, {cc, 3'h0});
            wr(8'h1F, {d, k, 1'b0});
            wr(8'h20, {d, k, 1'b0});
            settle;
            chk(PEAK_ATTACK_US_PER_DB, k <= 4'hC ? 17'h14 << k : 17'h0);
            chk(PEAK_RELEASE_MS_PER_DB, (k >= 4'h1 && k <= 4'hC) ? 14'h2 << k : 14'h0);
            chk({PEAK_HOLD_MS, HEADROOM_TRACK}, {hold[d], cc[0]});
            chk(HEADROOM_PERMILLE, h);
            chk({SAG3_DWELL_US, SAG3_ATTACK_TENTH_US}, {dwell[d], tenth[d]});
            chk({SAG3_ATTACK_STEP, SAG3_RELEASE_STEP}, {steps[k], steps[k]});
        end
        att(8'h00, 8'h01, 8'h00, 8'h01, 8'h2F, 7'h14, 7'h1E, 0, 0, 7'h2F, 3'h4);
        att(8'h00, 8'h01, 8'h00, 8'h01, 8'h28, 7'h14, 7'h1E, 0, 0, 7'h28, 3'h4);
        att(8'h00, 8'h01, 8'h00, 8'h01, 8'h7F, 7'h14, 7'h1E, 0, 0, 7'h2F, 3'h4);
        att(8'h20, 8'h01, 8'h00, 8'h01, 8'h2F, 7'h14, 7'h1E, 0, 0, 7'h1E, 3'h4);
        att(8'h20, 8'h01, 8'h80, 8'h01, 8'h2F, 7'h28, 7'h0A, 1, 0, 7'h0A, 3'h0);
        att(8'h20, 8'h01, 8'h00, 8'h01, 8'h2F, 7'h28, 7'h0A, 1, 0, 7'h28, 3'h4);
        att(8'h00, 8'h00, 8'h00, 8'h01, 8'h2F, 7'h28, 7'h0A, 0, 0, 7'h0A, 3'h0);
        att(8'h00, 8'h01, 8'h00, 8'h00, 8'h2F, 7'h14, 7'h1E, 0, 0, 7'h14, 3'h4);
        att(8'h00, 8'h00, 8'h00, 8'h01, 8'h2F, 7'h00, 7'h05, 0, 1, 7'h05, 3'h1);
        att(8'h00, 8'h00, 8'h00, 8'h03, 8'h2F, 7'h00, 7'h05, 0, 1, 7'h05, 3'h2);
        att(8'h00, 8'h00, 8'h00, 8'h02, 8'h2F, 7'h00, 7'h05, 0, 1, 7'h00, 3'h0);
        p0 = pulses;
        wr(8'h1E, 8'hB2);
        settle;
        chk(pulses - p0, 1);
        rd(8'h1E, 8'h32);
        wr(8'h1E, 8'h32);
        settle;
        chk(pulses - p0, 1);
        summarize;
    end
endmodule // gain_limiter_brownout_config_tb

// ==== tb/glb_asserts.sv ====
// Concurrent checks on the decoded outputs of the gain and brownout bank
`timescale 1ns/1ps
module glb_asserts (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic GP_OUT_LEVEL,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic SHARED_PIN_OUT,
    input wire logic SHARED_PIN_OE,
    input wire logic GAIN_ALIGN_PIN,
    input wire logic SAG_ALIGN_ON,
    input wire logic PEAK_ALIGN_ON,
    input wire logic [4:0] AUDIO_SLOT_BITS,
    input wire logic [7:0] VOLUME_HALF_DB,
    input wire logic VOLUME_MUTE,
    input wire logic [6:0] TOTAL_ATTEN_DB,
    input wire logic SAG_RUN,
    input wire logic SAG_MUTE_SHUTDOWN,
    input wire logic SAG_LEVEL0_ATTEN,
    input wire logic SAG_HOLD_RELEASE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_pin_drive;
        SHARED_PIN_OE |-> SHARED_PIN_OUT == $past(GP_OUT_LEVEL);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive level wrong");
    property p_pin_excl;
        SHARED_PIN_OE |-> !GAIN_ALIGN_PIN && !SAG_ALIGN_ON;
    endproperty
    a_pin_excl: assert property (p_pin_excl) else $error("pin modes overlap");
    property p_align;
        (SAG_ALIGN_ON || PEAK_ALIGN_ON) |-> GAIN_ALIGN_PIN;
    endproperty
    a_align: assert property (p_align) else $error("alignment without pin");
    property p_slot_len;
        $past(RST_N) |-> AUDIO_SLOT_BITS == 5'h10 || AUDIO_SLOT_BITS == 5'h18;
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("bad slot length");
    property p_mute;
        VOLUME_MUTE |-> VOLUME_HALF_DB == 8'hC8;
    endproperty
    a_mute: assert property (p_mute) else $error("mute without full step");
    property p_shut;
        SAG_MUTE_SHUTDOWN |-> SAG_RUN && !SAG_LEVEL0_ATTEN;
    endproperty
    a_shut: assert property (p_shut) else $error("level 0 action wrong");
    property p_cap;
        TOTAL_ATTEN_DB <= 7'h2F;
    endproperty
    a_cap: assert property (p_cap) else $error("attenuation above ceiling");
    property p_pulse;
        SAG_HOLD_RELEASE && !($past(REG_WR) && $past(REG_ADDR) == 8'h1E && $past(REG_WDATA[7]))
            |=> !SAG_HOLD_RELEASE;
    endproperty
    a_pulse: assert property (p_pulse) else $error("hold release too long");
    property p_clear_src;
        SAG_HOLD_RELEASE |-> $past(REG_WR, 2) && $past(REG_ADDR, 2) == 8'h1E
            && $past(REG_WDATA[7], 2);
    endproperty
    a_clear_src: assert property (p_clear_src) else $error("hold release unasked");
    c_hold: cover property (SAG_HOLD_RELEASE);
    c_mute: cover property (VOLUME_MUTE);
    c_drive: cover property (SHARED_PIN_OE ##1 SHARED_PIN_OE);
endmodule // glb_asserts
bind gain_limiter_brownout_config glb_asserts glb_asserts_inst (.*);
